// *** verilog/slpa_pkg.sv ***
// Package for the line/path overhead alarm register bank.
// Assumes an AXI4-Lite master with 32-bit data and one clock.
package slpa_pkg;
   // -------------------------------------------------------------
   // Register offsets (byte addresses are four times the index)
   // -------------------------------------------------------------
   localparam logic [7:0] IDX_MASTER_LOAD = 8'h00;
   localparam logic [7:0] IDX_LINE_CTRL = 8'h18;
   localparam logic [7:0] IDX_LINE_IRQ = 8'h19;
   localparam logic [7:0] IDX_LBE_LOW = 8'h1A;
   localparam logic [7:0] IDX_LBE_MID = 8'h1B;
   localparam logic [7:0] IDX_LBE_HIGH = 8'h1C;
   localparam logic [7:0] IDX_LFE_LOW = 8'h1D;
   localparam logic [7:0] IDX_LFE_MID = 8'h1E;
   localparam logic [7:0] IDX_LFE_HIGH = 8'h1F;
   localparam logic [7:0] IDX_TX_CTRL = 8'h20;
   localparam logic [7:0] IDX_TX_DIAG = 8'h21;
   localparam logic [7:0] IDX_PATH_STAT = 8'h30;
   localparam logic [7:0] IDX_PATH_IRQ = 8'h31;
   localparam logic [7:0] IDX_PATH_IRQ_EN = 8'h33;
   localparam logic [7:0] IDX_PATH_LABEL = 8'h37;
   localparam int ADDR_W = 10;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int LINE_FRAME_MODE_BIT = 7;
   localparam int PATH_RDI_BIT = 2;
   localparam int PATH_AIS_BIT = 3;
   localparam int PATH_LOP_BIT = 5;
   localparam int PATH_LABEL_BIT = 7;
   localparam int PATH_B3_BIT = 1;
   localparam int PATH_FEBE_BIT = 0;
   localparam logic [2:0] K2_RDI_CODE = 3'h6;
   localparam int CNT_W = 20;
   localparam int LABEL_CONFIRM = 3;
   // -------------------------------------------------------------
   // Timing and reset values
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int POLL_TIME_US = 7;
   // Longest time rounds down; we need only one cycle but keep bound
   localparam int POLL_CYCLES = POLL_TIME_US * CLK_MHZ;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic line_rdi;
      logic line_ais;
      logic path_rdi;
      logic path_ais;
      logic path_lop;
   } slpa_alarm_t;

   typedef struct packed {
      logic [4:0] b2_errs;
      logic line_febe;
      logic b3_err;
      logic path_febe;
      logic frame_start;
      logic c2_valid;
      logic [7:0] c2_byte;
   } slpa_event_t;
endpackage

// *** verilog/slpa_regs.sv ***
// Line and path overhead alarm, interrupt and error counter registers.
// Assumes alarm levels and error events are synchronous to aclk and
// that an AXI4-Lite master issues one write and one read at a time.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Line RDI change sets its status bit
// - Line AIS change sets its status bit
// - Any B2 error sets parity status bit
// - Nonzero line FEBE sets its status bit
// - Reading line irq register clears four bits
// - RDI enable gates RDI interrupt, resets zero
// - AIS enable gates AIS interrupt, resets zero
// - Parity enable gates parity interrupt, resets zero
// - 20-bit B2 snapshot in three bytes
// - 20-bit FEBE snapshot in three bytes
// - Write to any counter byte polls both
// - Poll copies counter and restarts from zero
// - Master load write polls all counters
// - Tx RDI bit forces K2 bits 110
// - Parity corrupt bit inverts transmitted B2
// - Path RDI, AIS, POINTER_LOSS_STATE live status bits
// - B3 and path FEBE set event bits
// - Path alarm changes set interrupt bits
// - Accepted label change sets label bit
// - Reading path irq register clears it
// - Frame mode counts B2 one per errored frame
// - Path enables gate path interrupt bits
// - Label accepted after three equal frames
module slpa_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [slpa_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [slpa_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire slpa_pkg::slpa_alarm_t alarm_in,
   input wire slpa_pkg::slpa_event_t event_in,
   input wire logic [7:0] tx_k2_in,
   input wire logic [7:0] tx_b2_in,
   output logic [7:0] tx_k2_out,
   output logic [7:0] tx_b2_out,
   output logic irq
);
   // -------------------------------------------------------------
   // Bus slave: write side
   // -------------------------------------------------------------
   logic aw_held_ff, w_held_ff;
   logic [7:0] aw_idx_ff;
   logic [7:0] wdata_ff;
   logic wr_go;
   logic ar_go;
   logic [7:0] ar_idx;

   assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
   assign ar_go = s_axi_arvalid && s_axi_arready;
   assign ar_idx = s_axi_araddr[slpa_pkg::ADDR_W-1:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         aw_idx_ff <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         aw_idx_ff <= s_axi_awaddr[slpa_pkg::ADDR_W-1:2];
      end else if (wr_go) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wdata_ff <= 8'h00;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         // Only the low lane carries register data
         wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : wdata_ff;
      end else if (wr_go) begin
         w_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= slpa_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped(aw_idx_ff) ? slpa_pkg::RESP_OKAY
                                                : slpa_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic wr_mapped(input logic [7:0] idx);
      case (idx)
         slpa_pkg::IDX_MASTER_LOAD, slpa_pkg::IDX_LINE_CTRL,
         slpa_pkg::IDX_LINE_IRQ, slpa_pkg::IDX_LBE_LOW,
         slpa_pkg::IDX_LBE_MID, slpa_pkg::IDX_LBE_HIGH,
         slpa_pkg::IDX_LFE_LOW, slpa_pkg::IDX_LFE_MID,
         slpa_pkg::IDX_LFE_HIGH, slpa_pkg::IDX_TX_CTRL,
         slpa_pkg::IDX_TX_DIAG, slpa_pkg::IDX_PATH_IRQ_EN:
            wr_mapped = 1'b1;
         default:
            wr_mapped = 1'b0;
      endcase
   endfunction

   // -------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------
   logic [3:0] line_en_ff;
   logic line_frame_mode_ff;
   logic tx_rdi_ff;
   logic tx_line_parity_corrupt_ff;
   logic [7:0] path_en_ff;
   logic poll;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_en_ff <= 4'h0;
         line_frame_mode_ff <= 1'b0;
         tx_rdi_ff <= 1'b0;
         tx_line_parity_corrupt_ff <= 1'b0;
         path_en_ff <= slpa_pkg::RESET_BYTE;
      end else if (wr_go) begin
         case (aw_idx_ff)
            slpa_pkg::IDX_LINE_IRQ: line_en_ff <= wdata_ff[7:4];
            slpa_pkg::IDX_LINE_CTRL:
               line_frame_mode_ff <= wdata_ff[slpa_pkg::LINE_FRAME_MODE_BIT];
            slpa_pkg::IDX_TX_CTRL: tx_rdi_ff <= wdata_ff[0];
            slpa_pkg::IDX_TX_DIAG: tx_line_parity_corrupt_ff <= wdata_ff[0];
            slpa_pkg::IDX_PATH_IRQ_EN: path_en_ff <= wdata_ff;
            default: ;
         endcase
      end
   end

   // Any counter byte or the master load address starts a poll
   assign poll = wr_go && ((aw_idx_ff >= slpa_pkg::IDX_LBE_LOW &&
                 aw_idx_ff <= slpa_pkg::IDX_LFE_HIGH) ||
                 aw_idx_ff == slpa_pkg::IDX_MASTER_LOAD);

   // -------------------------------------------------------------
   // Alarm edge detection and line counters
   // -------------------------------------------------------------
   slpa_pkg::slpa_alarm_t alarm_d_ff;
   logic frame_err_seen_ff;
   logic [slpa_pkg::CNT_W-1:0] lbe_acc_ff, lfe_acc_ff;
   logic [slpa_pkg::CNT_W-1:0] lbe_snap_ff, lfe_snap_ff;
   logic [slpa_pkg::CNT_W-1:0] lbe_inc, lfe_inc;
   logic b2_any;

   assign b2_any = |event_in.b2_errs;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_d_ff <= '0;
      end else begin
         alarm_d_ff <= alarm_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_err_seen_ff <= 1'b0;
      end else if (event_in.frame_start) begin
         frame_err_seen_ff <= b2_any;
      end else if (b2_any) begin
         frame_err_seen_ff <= 1'b1;
      end
   end

   always_comb begin
      lbe_inc = '0;
      if (line_frame_mode_ff) begin
         // One count per errored frame
         lbe_inc = {19'h00000, b2_any &&
                   (event_in.frame_start || !frame_err_seen_ff)};
      end else begin
         lbe_inc = {15'h0000, event_in.b2_errs};
      end
      lfe_inc = {19'h00000, event_in.line_febe};
   end

   // Snapshot and restart happen in one edge, so a coincident event
   // lands in the new interval rather than being lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lbe_acc_ff <= '0;
         lfe_acc_ff <= '0;
         lbe_snap_ff <= '0;
         lfe_snap_ff <= '0;
      end else if (poll) begin
         lbe_snap_ff <= lbe_acc_ff;
         lfe_snap_ff <= lfe_acc_ff;
         lbe_acc_ff <= lbe_inc;
         lfe_acc_ff <= lfe_inc;
      end else begin
         lbe_acc_ff <= lbe_acc_ff + lbe_inc;
         lfe_acc_ff <= lfe_acc_ff + lfe_inc;
      end
   end

   // -------------------------------------------------------------
   // Path signal label acceptance
   // -------------------------------------------------------------
   logic [7:0] label_ff, cand_ff;
   logic [1:0] cand_cnt_ff;
   logic label_change;

   assign label_change = event_in.c2_valid && event_in.c2_byte != label_ff
                         && event_in.c2_byte == cand_ff
                         && cand_cnt_ff == 2'(slpa_pkg::LABEL_CONFIRM - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         label_ff <= slpa_pkg::RESET_BYTE;
         cand_ff <= slpa_pkg::RESET_BYTE;
         cand_cnt_ff <= 2'h0;
      end else if (event_in.c2_valid) begin
         if (event_in.c2_byte == label_ff) begin
            cand_cnt_ff <= 2'h0;
         end else if (label_change) begin
            label_ff <= event_in.c2_byte;
            cand_cnt_ff <= 2'h0;
         end else if (event_in.c2_byte == cand_ff) begin
            cand_cnt_ff <= cand_cnt_ff + 2'h1;
         end else begin
            cand_ff <= event_in.c2_byte;
            cand_cnt_ff <= 2'h1;
         end
      end
   end

   // -------------------------------------------------------------
   // Sticky interrupt status
   // -------------------------------------------------------------
   logic [3:0] line_stat_ff, line_set;
   logic [7:0] path_stat_ff, path_set;
   logic rd_line_irq, rd_path_irq;

   assign rd_line_irq = ar_go && ar_idx == slpa_pkg::IDX_LINE_IRQ;
   assign rd_path_irq = ar_go && ar_idx == slpa_pkg::IDX_PATH_IRQ;

   always_comb begin
      line_set = 4'h0;
      line_set[0] = alarm_in.line_rdi ^ alarm_d_ff.line_rdi;
      line_set[1] = alarm_in.line_ais ^ alarm_d_ff.line_ais;
      line_set[2] = b2_any;
      line_set[3] = event_in.line_febe;
      path_set = 8'h00;
      path_set[slpa_pkg::PATH_FEBE_BIT] = event_in.path_febe;
      path_set[slpa_pkg::PATH_B3_BIT] = event_in.b3_err;
      path_set[slpa_pkg::PATH_RDI_BIT] =
         alarm_in.path_rdi ^ alarm_d_ff.path_rdi;
      path_set[slpa_pkg::PATH_AIS_BIT] =
         alarm_in.path_ais ^ alarm_d_ff.path_ais;
      path_set[slpa_pkg::PATH_LOP_BIT] =
         alarm_in.path_lop ^ alarm_d_ff.path_lop;
      path_set[slpa_pkg::PATH_LABEL_BIT] = label_change;
   end

   // Set wins over the read-clear so a coincident event is kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_stat_ff <= 4'h0;
         path_stat_ff <= 8'h00;
      end else begin
         line_stat_ff <= (rd_line_irq ? 4'h0 : line_stat_ff)
                         | line_set;
         path_stat_ff <= (rd_path_irq ? 8'h00 : path_stat_ff)
                         | path_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(line_stat_ff & line_en_ff) |
                |(path_stat_ff & path_en_ff);
      end
   end

   // -------------------------------------------------------------
   // Transmit overhead insertion
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_k2_out <= 8'h00;
         tx_b2_out <= 8'h00;
      end else begin
         // K2 bits 6..8 are the three least significant bits
         tx_k2_out <= tx_rdi_ff ? {tx_k2_in[7:3], slpa_pkg::K2_RDI_CODE}
                                : tx_k2_in;
         tx_b2_out <= tx_line_parity_corrupt_ff ? ~tx_b2_in
                                                : tx_b2_in;
      end
   end

   // -------------------------------------------------------------
   // Bus slave: read side
   // -------------------------------------------------------------
   logic [7:0] rd_byte;
   logic rd_ok;
   slpa_pkg::slpa_alarm_t live;

   assign live = alarm_d_ff;

   always_comb begin
      rd_byte = 8'h00;
      rd_ok = 1'b1;
      case (ar_idx)
         slpa_pkg::IDX_LINE_CTRL:
            rd_byte = {line_frame_mode_ff, 5'h00, live.line_ais, live.line_rdi};
         slpa_pkg::IDX_LINE_IRQ: rd_byte = {line_en_ff, line_stat_ff};
         slpa_pkg::IDX_LBE_LOW: rd_byte = lbe_snap_ff[7:0];
         slpa_pkg::IDX_LBE_MID: rd_byte = lbe_snap_ff[15:8];
         slpa_pkg::IDX_LBE_HIGH: rd_byte = {4'h0, lbe_snap_ff[19:16]};
         slpa_pkg::IDX_LFE_LOW: rd_byte = lfe_snap_ff[7:0];
         slpa_pkg::IDX_LFE_MID: rd_byte = lfe_snap_ff[15:8];
         slpa_pkg::IDX_LFE_HIGH: rd_byte = {4'h0, lfe_snap_ff[19:16]};
         slpa_pkg::IDX_TX_CTRL: rd_byte = {7'h00, tx_rdi_ff};
         slpa_pkg::IDX_TX_DIAG: rd_byte = {7'h00, tx_line_parity_corrupt_ff};
         slpa_pkg::IDX_PATH_STAT:
            rd_byte = {2'h0, live.path_lop, 1'b0, live.path_ais,
                       live.path_rdi, 2'h0};
         slpa_pkg::IDX_PATH_IRQ: rd_byte = path_stat_ff;
         slpa_pkg::IDX_PATH_IRQ_EN: rd_byte = path_en_ff;
         slpa_pkg::IDX_PATH_LABEL: rd_byte = label_ff;
         slpa_pkg::IDX_MASTER_LOAD: rd_byte = 8'h00;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= slpa_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_go;
         if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_ok ? slpa_pkg::RESP_OKAY
                                 : slpa_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// *** testbench/slpa_regs_sva.sv ***
// Assertion checker for the line/path alarm register bank.
// Sees only the top module ports; bound from the testbench top file.
`timescale 1ns/1ps
module slpa_regs_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] tx_k2_in,
   input wire logic [7:0] tx_b2_in,
   input wire logic [7:0] tx_k2_out,
   input wire logic [7:0] tx_b2_out
);
   logic [7:0] k2_ff;
   logic [7:0] b2_ff;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------------------------
   // Transmit overhead
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      k2_ff <= tx_k2_in;
      b2_ff <= tx_b2_in;
   end
   // Outputs stay zero for one edge after release, so wait two
   property p_k2_keep;
      $past(aresetn) && $past(aresetn, 2) |-> tx_k2_out[7:3] == k2_ff[7:3];
   endproperty
   a_k2_keep: assert property (p_k2_keep)
      else $error("K2 upper bits not passed through");
   property p_k2_rdi;
      $past(aresetn) && $past(aresetn, 2) |-> tx_k2_out[2:0] == k2_ff[2:0]
         || tx_k2_out[2:0] == slpa_pkg::K2_RDI_CODE;
   endproperty
   a_k2_rdi: assert property (p_k2_rdi)
      else $error("K2 low bits neither passed nor RDI code");
   property p_b2_inv;
      $past(aresetn) && $past(aresetn, 2) |-> tx_b2_out == b2_ff
         || tx_b2_out == ~b2_ff;
   endproperty
   a_b2_inv: assert property (p_b2_inv)
      else $error("B2 neither passed nor inverted");
   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   property p_w_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_w_ans: assert property (p_w_ans)
      else $error("write response missing");
   property p_r_ans;
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
   endproperty
   a_r_ans: assert property (p_r_ans)
      else $error("read response missing");
   property p_b_clr;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_clr: assert property (p_b_clr)
      else $error("bvalid held after handshake");
   property p_r_clr;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_clr: assert property (p_r_clr)
      else $error("rvalid held after handshake");
   property p_r_hi;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready;
   endproperty
   a_r_hi: assert property (p_r_hi)
      else $error("read upper bits set or address accepted");
endmodule

// *** testbench/slpa_regs_tb.sv ***
// Self-checking bench for the line/path alarm register bank.
// Drives AXI4-Lite, alarm levels, error events and transmit bytes.
`timescale 1ns/1ps
module slpa_regs_tb;
   typedef struct {
      logic [7:0] idx, w, r;
      logic [1:0] rs;
   } slpa_row_t;
   localparam logic [1:0] OK = slpa_pkg::RESP_OKAY;
   localparam logic [1:0] ER = slpa_pkg::RESP_SLVERR;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] k2_i, b2_i, k2_o, b2_o;
   slpa_pkg::slpa_alarm_t al;
   slpa_pkg::slpa_event_t ev;
   int fail_count, n_tests, cyc;
   slpa_row_t rows[9] = '{'{8'h18, 8'h80, 8'h80, OK},
      '{8'h18, 8'h00, 8'h00, OK}, '{8'h19, 8'hF0, 8'hF0, OK},
      '{8'h19, 8'h00, 8'h00, OK}, '{8'h20, 8'h01, 8'h01, OK},
      '{8'h21, 8'h01, 8'h01, OK}, '{8'h33, 8'hAF, 8'hAF, OK},
      '{8'h05, 8'hFF, 8'h00, ER}, '{8'h1B, 8'hFF, 8'h00, OK}};
   logic [7:0] rst_idx[14] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D,
      8'h1E, 8'h1F, 8'h20, 8'h21, 8'h30, 8'h31, 8'h33, 8'h37};
   slpa_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .alarm_in(al), .event_in(ev),
      .tx_k2_in(k2_i), .tx_b2_in(b2_i), .tx_k2_out(k2_o),
      .tx_b2_out(b2_o), .irq(irq));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      awaddr <= {i, 2'h0};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, {24'h000000, d});
      chk(rresp, er);
   endtask
   task automatic pulse(input slpa_pkg::slpa_event_t e);
      @(posedge aclk);
      ev <= e;
      @(posedge aclk);
      ev <= '0;
   endtask
   // B2 error count n held for c cycles, optional frame start
   task automatic b2(input logic [4:0] n, input int c, input logic fs);
      @(posedge aclk);
      ev.b2_errs <= n;
      ev.frame_start <= fs;
      @(posedge aclk);
      ev.frame_start <= 1'b0;
      repeat (c - 1) @(posedge aclk);
      ev.b2_errs <= 5'h00;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // Whole run needs about 3000 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, al, ev} = '0;
      k2_i = 8'hA9;
      b2_i = 8'h5C;
      tick(20);
      aresetn <= 1'b1;
      tick(2);
      foreach (rst_idx[i]) rd(rst_idx[i], 8'h00, OK);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].w, rows[i].rs);
         rd(rows[i].idx, rows[i].r, rows[i].rs);
      end
      $display("test registers done");
      chk(k2_o, {k2_i[7:3], slpa_pkg::K2_RDI_CODE});
      chk(b2_o, {24'h000000, ~b2_i});
      wr(8'h20, 8'h00, OK);
      wr(8'h21, 8'h00, OK);
      tick(2);
      chk(k2_o, k2_i);
      chk(b2_o, b2_i);
      $display("test transmit done");
      al.line_rdi <= 1'b1;
      tick(3);
      chk(irq, 1'b0);
      rd(8'h19, 8'h01, OK);
      rd(8'h19, 8'h00, OK);
      wr(8'h19, 8'hF0, OK);
      al.line_rdi <= 1'b0;
      al.line_ais <= 1'b1;
      tick(3);
      chk(irq, 1'b1);
      rd(8'h19, 8'hF3, OK);
      tick(3);
      chk(irq, 1'b0);
      $display("test line alarms done");
      wr(8'h1A, 8'h00, OK);
      b2(5'd24, 2731, 1'b0);
      repeat (3) pulse('{line_febe: 1'b1, default: '0});
      tick(3);
      chk(irq, 1'b1);
      wr(slpa_pkg::IDX_MASTER_LOAD, 8'h00, OK);
      rd(8'h1A, 8'h08, OK);
      rd(8'h1B, 8'h00, OK);
      rd(8'h1C, 8'h01, OK);
      rd(8'h1D, 8'h03, OK);
      rd(8'h1F, 8'h00, OK);
      rd(8'h19, 8'hFC, OK);
      wr(8'h1D, 8'h00, OK);
      rd(8'h1A, 8'h00, OK);
      rd(8'h1D, 8'h00, OK);
      wr(8'h18, 8'h80, OK);
      b2(5'd2, 3, 1'b1);
      b2(5'd1, 1, 1'b1);
      wr(8'h1F, 8'h00, OK);
      rd(8'h1A, 8'h02, OK);
      // Clear the parity status so the path irq checks see only path bits
      rd(8'h19, 8'hF4, OK);
      $display("test counters done");
      al.path_rdi <= 1'b1;
      al.path_lop <= 1'b1;
      pulse('{b3_err: 1'b1, path_febe: 1'b1, default: '0});
      repeat (3) pulse('{c2_valid: 1'b1, c2_byte: 8'h13, default: '0});
      tick(3);
      chk(irq, 1'b1);
      rd(8'h30, 8'h24, OK);
      rd(8'h37, 8'h13, OK);
      rd(8'h31, 8'hA7, OK);
      tick(3);
      chk(irq, 1'b0);
      repeat (2) pulse('{c2_valid: 1'b1, c2_byte: 8'h55, default: '0});
      pulse('{c2_valid: 1'b1, c2_byte: 8'h13, default: '0});
      rd(8'h37, 8'h13, OK);
      rd(8'h31, 8'h00, OK);
      $display("test path done");
      // ---------------------------------------------------------------
      // Reset in mid-run with an enabled status bit and tx RDI set
      // ---------------------------------------------------------------
      wr(8'h20, 8'h01, OK);
      al.line_ais <= 1'b0;
      tick(3);
      chk(irq, 1'b1);
      aresetn <= 1'b0;
      tick(3);
      aresetn <= 1'b1;
      tick(2);
      chk(irq, 1'b0);
      chk(k2_o, k2_i);
      rd(8'h20, 8'h00, OK);
      rd(8'h19, 8'h00, OK);
      $display("test mid-run reset done");
      summarize();
   end
endmodule
bind slpa_regs slpa_regs_sva chk_u (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .tx_k2_in, .tx_b2_in, .tx_k2_out,
   .tx_b2_out);
